// file: src/pmt_pkg.sv
// package for the 8-bit period match timer
// assumes a single 100 MHz bus clock and an AHB-Lite register port
package pmt_pkg;

  // ----------------------------------------
  // register map (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] PMT_COUNT_OFS = 8'h00;
  localparam logic [7:0] PMT_LIMIT_OFS = 8'h04;
  localparam logic [7:0] PMT_CTRL_OFS = 8'h08;
  localparam logic [7:0] PMT_FLAG_OFS = 8'h0c;
  localparam logic [7:0] PMT_ENABLE_OFS = 8'h10;

  // ----------------------------------------
  // reset values and field positions
  // ----------------------------------------
  localparam logic [7:0] PMT_COUNT_RST = 8'h00;
  localparam logic [7:0] PMT_LIMIT_RST = 8'hff;
  localparam logic [6:0] PMT_CTRL_RST = 7'h00;
  localparam int PMT_RUN_BIT = 2;
  localparam int PMT_MDIV_LSB = 3;

  // instruction clock is the core clock divided by four
  localparam logic [1:0] PMT_ICLK_DIV = 2'h3;
  localparam logic [1:0] PMT_ICLK_RST = 2'h0;

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef struct packed {
    logic [3:0] match_divide_select;
    logic timer_run_bit;
    logic [1:0] input_divide_select;
  } pmt_ctrl_type;

  typedef enum logic [2:0] {
    PMT_IDLE = 3'b001,
    PMT_WRITE = 3'b010,
    PMT_READ = 3'b100
  } pmt_bus_state_type;

endpackage : pmt_pkg

// file: src/pmt_prescaler.sv
// input prescaler: divides instruction ticks by 1, 4, 16 or 64
// assumes tick_in is a one-cycle pulse on hclk
`timescale 1ns/100ps
module pmt_prescaler
  import pmt_pkg::*;
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // control
  input wire logic clear,
  input wire logic [1:0] input_divide_select,
  input wire logic tick_in,
  // result
  output logic tick_out
);

  logic [5:0] count;
  logic [5:0] terminal;

  // divide select decode
  assign terminal = (input_divide_select == 2'h0) ? 6'h00 :
                    (input_divide_select == 2'h1) ? 6'h03 :
                    (input_divide_select == 2'h2) ? 6'h0f : 6'h3f;
  assign tick_out = tick_in && (count == terminal);

  // prescale counter, cleared by count or control writes and reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count <= 6'h00;
    end else if (clear) begin
      count <= 6'h00;
    end else if (tick_in) begin
      count <= (count >= terminal) ? 6'h00 : 6'(count + 6'h01);
    end
  end

endmodule : pmt_prescaler

// file: src/pmt_postscaler.sv
// match postscaler: one output pulse for every N+1 match pulses
// assumes match_in is a one-cycle pulse on hclk
`timescale 1ns/100ps
module pmt_postscaler
  import pmt_pkg::*;
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // control
  input wire logic clear,
  input wire logic [3:0] match_divide_select,
  input wire logic match_in,
  // result
  output logic event_out
);

  logic [3:0] count;

  assign event_out = match_in && (count >= match_divide_select);

  // postscale counter; a lowered ratio wraps at once instead of running on
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count <= 4'h0;
    end else if (clear) begin
      count <= 4'h0;
    end else if (match_in) begin
      count <= event_out ? 4'h0 : 4'(count + 4'h1);
    end
  end

endmodule : pmt_postscaler

// file: src/pmt_timer.sv
// 8-bit period match timer with AHB-Lite register slave
// assumes one clock hclk at 100 MHz, a single master, sleep from the core
//
// The address map and the AHB-Lite interface to the registers were left to the implementer.
`timescale 1ns/100ps
module pmt_timer
  import pmt_pkg::*;
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // core sleep, from outside the clock domain
  input wire logic sleep,
  // pulse width unit time base and interrupt
  output logic match_out,
  output logic irq
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  logic [7:0] period_count;
  logic [7:0] period_limit;
  pmt_ctrl_type timer_control_reg;
  logic match_irq_flag;
  logic match_irq_enable;
  logic [1:0] iclk_div;
  logic sleep_meta;
  logic sleep_sync;
  logic match_pending;
  pmt_bus_state_type bus_state;
  logic [7:0] addr_q;

  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  // one compare for every register select, so the map stays in one place
  function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] ofs);
    return addr == ofs;
  endfunction : reg_hit

  wire access_ok = hsel && hready && htrans[1];
  wire wr_phase = (bus_state == PMT_WRITE);
  wire wr_count = wr_phase && reg_hit(addr_q, PMT_COUNT_OFS);
  wire wr_limit = wr_phase && reg_hit(addr_q, PMT_LIMIT_OFS);
  wire wr_ctrl = wr_phase && reg_hit(addr_q, PMT_CTRL_OFS);
  wire wr_flag = wr_phase && reg_hit(addr_q, PMT_FLAG_OFS);
  wire wr_enable = wr_phase && reg_hit(addr_q, PMT_ENABLE_OFS);
  // count and control writes restart both scalers so a new ratio begins on a clean boundary
  wire scaler_clear = wr_count || wr_ctrl;
  logic [31:0] read_value;

  // read mux, unmapped reads return zero
  always_comb begin
    if (reg_hit(haddr, PMT_COUNT_OFS)) begin
      read_value = {24'h0, period_count};
    end else if (reg_hit(haddr, PMT_LIMIT_OFS)) begin
      read_value = {24'h0, period_limit};
    end else if (reg_hit(haddr, PMT_CTRL_OFS)) begin
      read_value = {25'h0, timer_control_reg};
    end else if (reg_hit(haddr, PMT_FLAG_OFS)) begin
      read_value = {31'h0, match_irq_flag};
    end else if (reg_hit(haddr, PMT_ENABLE_OFS)) begin
      read_value = {31'h0, match_irq_enable};
    end else begin
      read_value = 32'h0;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // address phase capture; zero wait states
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_state <= PMT_IDLE;
      addr_q <= 8'h00;
      hrdata <= 32'h0;
    end else begin
      case (bus_state)
        PMT_IDLE, PMT_WRITE, PMT_READ: begin
          if (access_ok && hwrite) begin
            bus_state <= PMT_WRITE;
          end else if (access_ok) begin
            bus_state <= PMT_READ;
          end else begin
            bus_state <= PMT_IDLE;
          end
        end
        default: begin
          bus_state <= PMT_IDLE;
        end
      endcase
      if (access_ok) begin
        addr_q <= haddr;
      end
      if (access_ok && !hwrite) begin
        hrdata <= read_value;
      end
    end
  end

  // ----------------------------------------
  // instruction clock tick and sleep sync
  // ----------------------------------------
  wire iclk_tick = (iclk_div == PMT_ICLK_DIV);
  wire run_tick = iclk_tick && timer_control_reg.timer_run_bit && !sleep_sync;

  // divide by four for the instruction clock; sleep passes two flops
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      iclk_div <= PMT_ICLK_RST;
      sleep_meta <= 1'b0;
      sleep_sync <= 1'b0;
    end else begin
      iclk_div <= 2'(iclk_div + 2'h1);
      sleep_meta <= sleep;
      sleep_sync <= sleep_meta;
    end
  end

  logic pre_tick;
  logic post_event;

  pmt_prescaler pmt_prescaler_inst (
    .hclk(hclk),
    .hresetn(hresetn),
    .clear(scaler_clear),
    .input_divide_select(timer_control_reg.input_divide_select),
    .tick_in(run_tick),
    .tick_out(pre_tick)
  );

  // ----------------------------------------
  // compare and count
  // ----------------------------------------
  wire equal_now = (period_count == period_limit);
  // one match pulse per equal period, given on the tick that restarts
  wire match_pulse = pre_tick && equal_now;
  assign match_out = match_pending;

  // count register; software write has priority over the hardware
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      period_count <= PMT_COUNT_RST;
      period_limit <= PMT_LIMIT_RST;
      timer_control_reg <= PMT_CTRL_RST;
      match_pending <= 1'b0;
    end else begin
      match_pending <= match_pulse;
      if (wr_count) begin
        period_count <= hwdata[7:0];
      end else if (match_pulse) begin
        period_count <= PMT_COUNT_RST;
      end else if (pre_tick) begin
        period_count <= 8'(period_count + 8'h01);
      end
      if (wr_limit) begin
        period_limit <= hwdata[7:0];
      end
      if (wr_ctrl) begin
        timer_control_reg <= pmt_ctrl_type'(hwdata[6:0]);
      end
    end
  end

  pmt_postscaler pmt_postscaler_inst (
    .hclk(hclk),
    .hresetn(hresetn),
    .clear(scaler_clear),
    .match_divide_select(timer_control_reg.match_divide_select),
    .match_in(match_pulse),
    .event_out(post_event)
  );

  // ----------------------------------------
  // interrupt flag and enable
  // ----------------------------------------
  // set wins over a write-one clear in the same cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      match_irq_flag <= 1'b0;
      match_irq_enable <= 1'b0;
    end else begin
      if (post_event) begin
        match_irq_flag <= 1'b1;
      end else if (wr_flag && hwdata[0]) begin
        match_irq_flag <= 1'b0;
      end
      if (wr_enable) begin
        match_irq_enable <= hwdata[0];
      end
    end
  end

  assign irq = match_irq_flag && match_irq_enable;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  count_reset_a: assert property (@(posedge hclk) disable iff (!hresetn)
    match_pulse && !wr_count |=> period_count == 8'h00)
    else $error("count not cleared after match");
  count_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !pre_tick && !wr_count |=> $stable(period_count))
    else $error("count moved without tick");
  count_step_a: assert property (@(posedge hclk) disable iff (!hresetn)
    pre_tick && !equal_now && !wr_count |=> period_count == 8'($past(period_count) + 8'h01))
    else $error("count did not step");
  write_wins_a: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_count |=> period_count == $past(hwdata[7:0]))
    else $error("count write lost");
  match_out_a: assert property (@(posedge hclk) disable iff (!hresetn)
    match_pulse |=> match_out)
    else $error("match not forwarded");
  flag_set_a: assert property (@(posedge hclk) disable iff (!hresetn)
    post_event |=> match_irq_flag)
    else $error("flag not set");
  irq_gate_a: assert property (@(posedge hclk) disable iff (!hresetn)
    post_event && match_irq_enable && !wr_enable |=> irq)
    else $error("irq not raised while enabled");
  sleep_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
    sleep_sync && !wr_count |=> $stable(period_count))
    else $error("count moved in sleep");
  tick_rate_a: assert property (@(posedge hclk) disable iff (!hresetn)
    iclk_tick |=> !iclk_tick [*3])
    else $error("instruction tick too often");
  ctrl_keep_a: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_ctrl && !pre_tick |=> $stable(period_count))
    else $error("control write changed count");
  // register and flag bookkeeping
  limit_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_limit |=> period_limit == $past(hwdata[7:0]))
    else $error("limit write lost");
  limit_keep_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !wr_limit |=> $stable(period_limit))
    else $error("limit changed without write");
  ctrl_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_ctrl |=> timer_control_reg == pmt_ctrl_type'($past(hwdata[6:0])))
    else $error("control write lost");
  ctrl_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !wr_ctrl |=> $stable(timer_control_reg))
    else $error("control changed without write");
  flag_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_flag && hwdata[0] && !post_event |=> !match_irq_flag)
    else $error("flag not cleared");
  flag_latch_a: assert property (@(posedge hclk) disable iff (!hresetn)
    match_irq_flag && !wr_flag |=> match_irq_flag)
    else $error("flag dropped by itself");
  flag_cause_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !match_irq_flag && !post_event |=> !match_irq_flag)
    else $error("flag set without event");
  enable_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_enable |=> match_irq_enable == $past(hwdata[0]))
    else $error("enable write lost");
  run_gate_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !timer_control_reg.timer_run_bit |-> !pre_tick)
    else $error("tick while stopped");
  count_read_a: assert property (@(posedge hclk) disable iff (!hresetn)
    access_ok && !hwrite && reg_hit(haddr, PMT_COUNT_OFS) |=>
    hrdata == {24'h000000, $past(period_count)})
    else $error("count read wrong");
  hrdata_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !(access_ok && !hwrite) |=> $stable(hrdata))
    else $error("read data moved without read");
  match_single_a: assert property (@(posedge hclk) disable iff (!hresetn)
    match_out |=> !match_out)
    else $error("match pulse too long");
  // scaler clears reach inside the two counters
  pre_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
    scaler_clear |=> pmt_prescaler_inst.count == 6'h00)
    else $error("prescaler not cleared");
  post_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
    scaler_clear |=> pmt_postscaler_inst.count == 4'h0)
    else $error("postscaler not cleared");

endmodule : pmt_timer

// file: verif/pmt_pwm_model.sv
// pulse width unit stand-in: counts time-base pulses and their spacing
// assumes match_out is a one-cycle pulse on hclk
`timescale 1ns/100ps
module pmt_pwm_model (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // time base from the timer
  input wire logic match_out,
  // observations
  output logic [15:0] match_total,
  output logic [15:0] last_gap
);
  logic [15:0] gap_run;
  // gap restarts at each pulse, so last_gap is the period in hclk cycles
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      match_total <= 16'h0000;
      last_gap <= 16'h0000;
      gap_run <= 16'h0001;
    end else if (match_out) begin
      match_total <= match_total + 16'h0001;
      last_gap <= gap_run;
      gap_run <= 16'h0001;
    end else begin
      gap_run <= gap_run + 16'h0001;
    end
  end
endmodule : pmt_pwm_model

// file: verif/pmt_timer_tb_top.sv
// self-checking bench for the period match timer
// assumes zero-wait slave; the master still waits on hreadyout
`timescale 1ns/100ps
module pmt_timer_tb_top;
  import pmt_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hready, sleep;
  logic [7:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, r1, r2;
  logic hreadyout, hresp, match_out, irq;
  logic [15:0] match_total, last_gap, m0;
  int miscompares = 0;
  int comparisons = 0;
  assign hready = hreadyout;
  pmt_timer pmt_timer_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .sleep(sleep),
    .match_out(match_out), .irq(irq));
  pmt_pwm_model pmt_pwm_model_inst (.hclk(hclk), .hresetn(hresetn),
    .match_out(match_out), .match_total(match_total), .last_gap(last_gap));
  // ----------------------------------------
  // bus and compare helpers
  // ----------------------------------------
  task automatic check(input string nm, input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask : check
  task automatic edge_ready();
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
  endtask : edge_ready
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    edge_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    edge_ready();
    r = hrdata;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, r1);
  endtask : wr
  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0, r2);
    check(nm, r2, e);
    check("hresp", {31'h0, hresp}, 32'h0);
  endtask : rd
  function automatic logic [31:0] ctl(input logic [3:0] m, input logic on,
                                      input logic [1:0] p);
    return {25'h0, m, on, p};
  endfunction : ctl
  task automatic wait_matches(input logic [15:0] k);
    m0 = match_total;
    for (int n = 0; n < 3000 && match_total - m0 < k; n++) @(posedge hclk);
    check("match wait", {31'h0, match_total - m0 >= k}, 32'h1);
  endtask : wait_matches
  task automatic summarize();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : summarize
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    rd("count", PMT_COUNT_OFS, 32'h0);
    rd("limit", PMT_LIMIT_OFS, 32'hff);
    rd("ctrl", PMT_CTRL_OFS, 32'h0);
    rd("unmapped", 8'h14, 32'h0);
  endtask : t_reset
  task automatic t_regs();
    wr(PMT_COUNT_OFS, 32'hffff_ff77);
    rd("count", PMT_COUNT_OFS, 32'h77);
    wr(PMT_LIMIT_OFS, 32'h3c);
    rd("limit", PMT_LIMIT_OFS, 32'h3c);
    wr(PMT_CTRL_OFS, ctl(4'h2, 1'b0, 2'h1));
    rd("count kept", PMT_COUNT_OFS, 32'h77);
    rd("ctrl", PMT_CTRL_OFS, 32'h11);
  endtask : t_regs
  // period is (limit+1) steps of 4 hclk times the prescale ratio
  task automatic t_prescale();
    wr(PMT_LIMIT_OFS, 32'h1);
    for (int p = 0; p < 4; p++) begin
      wr(PMT_CTRL_OFS, ctl(4'h0, 1'b1, p[1:0]));
      wait_matches(16'h3);
      check("gap", {16'h0, last_gap}, 32'h8 << (2 * p));
    end
  endtask : t_prescale
  task automatic t_post();
    logic [3:0] mt [3] = '{4'h0, 4'h3, 4'hf};
    wr(PMT_ENABLE_OFS, 32'h1);
    foreach (mt[i]) begin
      wr(PMT_CTRL_OFS, 32'h0);
      wr(PMT_FLAG_OFS, 32'h1);
      wr(PMT_CTRL_OFS, ctl(mt[i], 1'b1, 2'h0));
      m0 = match_total;
      for (int n = 0; n < 300 && irq !== 1'b1; n++) @(posedge hclk);
      repeat (2) @(posedge hclk);
      check("matches", {16'h0, match_total - m0}, {28'h0, mt[i]} + 1);
      check("irq", {31'h0, irq}, 32'h1);
    end
    wr(PMT_ENABLE_OFS, 32'h0);
    @(posedge hclk);
    check("irq masked", {31'h0, irq}, 32'h0);
    rd("flag", PMT_FLAG_OFS, 32'h1);
    wr(PMT_CTRL_OFS, 32'h0);
    wr(PMT_FLAG_OFS, 32'h1);
    rd("flag clear", PMT_FLAG_OFS, 32'h0);
  endtask : t_post
  // run bit cleared, then sleep, must both freeze the count
  task automatic t_hold();
    logic [31:0] a;
    wr(PMT_LIMIT_OFS, 32'hc0);
    for (int s = 0; s < 2; s++) begin
      wr(PMT_CTRL_OFS, ctl(4'h0, s[0], 2'h0));
      sleep <= s[0];
      repeat (5) @(posedge hclk);
      bus(1'b0, PMT_COUNT_OFS, 32'h0, a);
      repeat (40) @(posedge hclk);
      rd("held", PMT_COUNT_OFS, a);
    end
    sleep <= 1'b0;
    repeat (40) @(posedge hclk);
    bus(1'b0, PMT_COUNT_OFS, 32'h0, r1);
    check("runs", {31'h0, r1 != a}, 32'h1);
    wr(PMT_COUNT_OFS, 32'h7);
    rd("write wins", PMT_COUNT_OFS, 32'h7);
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd("count rst", PMT_COUNT_OFS, 32'h0);
    rd("limit rst", PMT_LIMIT_OFS, 32'hff);
  endtask : t_hold
  // clock, stimulus and watchdog
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  initial begin
    {hresetn, hsel, hwrite, sleep, haddr, htrans, hwdata} = '0;
    hsize = 3'h2;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset();
    t_regs();
    t_prescale();
    t_post();
    t_hold();
    summarize();
  end
  initial begin
    #300000;
    miscompares++;
    summarize();
  end
endmodule : pmt_timer_tb_top
